/* logic/sdm_device.sv */
// DRAM device core: power-up sequencing, mode register, burst addressing
`timescale 1ns/100ps
`include "sdm_cfg.svh"

module sdm_fifo #(
  parameter int W = 27,
  parameter int D = 32
) (
  input  wire logic         clock,
  input  wire logic         reset,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  assign in_ready  = cnt_q != D[AW:0];
  assign out_valid = cnt_q != '0;
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

module sdm_device
  import sdm_pkg::*;
#(
  parameter int PWR_CYC = `SDM_PWR_CYC
) (
  input  wire logic                   clock,
  input  wire logic                   reset,
  input  wire logic                   cke,
  input  wire logic                   cs_n,
  input  wire logic                   ras_n,
  input  wire logic                   cas_n,
  input  wire logic                   we_n,
  input  wire logic                   bank_select_low,
  input  wire logic                   bank_select_high,
  input  wire logic [`SDM_MODE_W-1:0] addr,
  input  wire logic [`SDM_DQ_W-1:0]   dq_in,
  output logic      [`SDM_DQ_W-1:0]   dq_out,
  output logic                        dq_oe_n,
  output logic                        init_ready,
  output logic                        seq_error,
  output logic      [`SDM_MODE_W-1:0] mode_value,
  output logic                        wr_fifo_ready
);
  localparam int CW = `SDM_COL_W;
  localparam int AWM = CW + 2;
  localparam int FW = AWM + `SDM_DQ_W;
  localparam logic [3:0] PRECHARGE_WAIT_TIME = 4'(`SDM_TRP_CYC);
  localparam logic [3:0] REFRESH_CYCLE_WAIT_TIME = 4'(`SDM_REFRESH_CYCLE_WAIT_TIME_CYC);
  localparam logic [3:0] MODE_LOAD_WAIT_TIME = 4'(`SDM_MODE_LOAD_WAIT_TIME_CYC);

  sdm_state_t           state_q;
  sdm_cmd_t             cmd;
  logic [31:0]          pwr_q;
  logic [3:0]           gap_q;
  logic [1:0]           ref_q;
  logic                 loaded_q;
  logic                 err_q;
  logic [`SDM_MODE_W-1:0] mode_q;
  logic [2:0]           burst_count_setting;
  logic                 burst_order_bit;
  logic [2:0]           read_latency_setting;
  logic                 write_burst_mode_bit;
  logic                 page_mode;
  logic                 lat3;
  logic                 mode_load_command;
  logic                 load_ok;
  logic                 rw_go;
  logic                 rw_write;
  logic                 stop;
  logic                 beat;
  logic [CW-1:0]        col;
  logic [3:0]           len_new;
  logic                 act_q;
  logic                 wr_q;
  logic [3:0]           len_q;
  logic                 page_q;
  logic [CW-1:0]        start_q;
  logic [CW-1:0]        beat_q;
  logic [1:0]           bank_q;
  logic [1:0]           bank;
  logic [`SDM_DQ_W-1:0] mem [2**AWM];
  logic [1:0]           pv_q;
  logic [`SDM_DQ_W-1:0] pd0_q;
  logic [`SDM_DQ_W-1:0] pd1_q;
  logic [`SDM_DQ_W-1:0] dq_q;
  logic                 oe_n_q;
  logic                 rd_beat;
  logic                 wr_beat;
  logic                 drain_valid;
  logic [FW-1:0]        drain_data;

  // Burst length in locations for a fixed-length code; reserved codes fall back to one
  function automatic logic [3:0] len_of(input logic [2:0] code);
    case (code)
      `SDM_LEN_2: len_of = 4'h2;
      `SDM_LEN_4: len_of = 4'h4;
      `SDM_LEN_8: len_of = 4'h8;
      default:    len_of = 4'h1;
    endcase
  endfunction

  // Column of a given beat within its block or page
  function automatic logic [CW-1:0] col_of(
    input logic [CW-1:0] start,
    input logic [CW-1:0] n,
    input logic [3:0]    len,
    input logic          page,
    input logic          ilv
  );
    logic [CW-1:0] mask;
    mask = CW'(len) - 1'b1;
    if (page) begin
      col_of = start + n;
    end else if (ilv && len != 4'h1) begin
      col_of = (start & ~mask) | ((start ^ n) & mask);
    end else begin
      col_of = (start & ~mask) | ((start + n) & mask);
    end
  endfunction

  assign cmd = (cke && !cs_n) ? sdm_cmd_t'({ras_n, cas_n, we_n}) : SDM_CMD_NOP;
  assign bank = {bank_select_high, bank_select_low};

  // Field decode of the loaded mode value
  assign burst_count_setting  = mode_q[`SDM_F_LEN_HI:`SDM_F_LEN_LO];
  assign burst_order_bit      = mode_q[`SDM_F_ORDER];
  assign read_latency_setting = mode_q[`SDM_F_LAT_HI:`SDM_F_LAT_LO];
  assign write_burst_mode_bit = mode_q[`SDM_F_WBM];
  assign page_mode = burst_count_setting == `SDM_LEN_PAGE && !burst_order_bit;
  assign lat3 = read_latency_setting == `SDM_LAT_3;

  assign mode_load_command = cmd == SDM_CMD_LOAD && bank == 2'h0;
  // Loads are taken only with both bank bits zero, in setup or ready, and no wait pending
  assign load_ok = mode_load_command && gap_q == '0 &&
                   (state_q == SDM_ST_SETUP || state_q == SDM_ST_READY);

  // Initialization sequencer: tracks the controller's power-up steps
  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= SDM_ST_POWER;
      pwr_q   <= '0;
      gap_q   <= '0;
      ref_q   <= '0;
    end else begin
      if (gap_q != '0) begin
        gap_q <= gap_q - 1'b1;
      end
      case (state_q)
        SDM_ST_POWER: begin
          if (pwr_q < 32'(PWR_CYC)) begin
            pwr_q <= pwr_q + 1'b1;
          end else if (cmd == SDM_CMD_PRE && addr[`SDM_AP_BIT]) begin
            state_q <= SDM_ST_PRECH;
            gap_q   <= PRECHARGE_WAIT_TIME - 1'b1;
          end
        end
        SDM_ST_PRECH: begin
          if (gap_q == '0) begin
            state_q <= SDM_ST_SETUP;
          end
        end
        SDM_ST_SETUP: begin
          if (gap_q == '0 && cmd == SDM_CMD_REF) begin
            gap_q <= REFRESH_CYCLE_WAIT_TIME - 1'b1;
            if (ref_q != 2'h3) begin
              ref_q <= ref_q + 1'b1;
            end
          end else if (load_ok) begin
            gap_q <= MODE_LOAD_WAIT_TIME - 1'b1;
          end else if (gap_q == '0 && loaded_q && ref_q >= 2'(`SDM_REF_MIN)) begin
            state_q <= SDM_ST_READY;
          end
        end
        SDM_ST_READY: begin
          if (load_ok) begin
            gap_q <= MODE_LOAD_WAIT_TIME - 1'b1;
          end else if (cmd == SDM_CMD_REF) begin
            gap_q <= REFRESH_CYCLE_WAIT_TIME - 1'b1;
          end
        end
        default: state_q <= SDM_ST_POWER;
      endcase
    end
  end

  // Any command other than NOP in a wait window or the power-up wait, reads, writes and activates before ready, and refused loads
  always_ff @(posedge clock) begin
    if (reset) begin
      err_q <= 1'b0;
    end else if (cmd != SDM_CMD_NOP) begin
      if (state_q == SDM_ST_POWER && pwr_q < 32'(PWR_CYC)) begin
        err_q <= 1'b1;
      end else if (gap_q != '0 || state_q == SDM_ST_PRECH) begin
        err_q <= 1'b1;
      end else if (state_q != SDM_ST_READY &&
                   (cmd == SDM_CMD_READ || cmd == SDM_CMD_WRITE || cmd == SDM_CMD_ACT)) begin
        err_q <= 1'b1;
      end else if (cmd == SDM_CMD_LOAD && !load_ok) begin
        err_q <= 1'b1;
      end
    end
  end

  // Mode register: zero from reset until loaded, held until the next load
  always_ff @(posedge clock) begin
    if (reset) begin
      mode_q   <= `SDM_MODE_RST;
      loaded_q <= 1'b0;
    end else if (load_ok) begin
      mode_q   <= addr;
      loaded_q <= 1'b1;
    end
  end

  assign rw_go    = state_q == SDM_ST_READY && gap_q == '0 &&
                    (cmd == SDM_CMD_READ || cmd == SDM_CMD_WRITE);
  assign rw_write = cmd == SDM_CMD_WRITE;
  assign stop     = cmd == SDM_CMD_BST || cmd == SDM_CMD_PRE || load_ok;
  assign len_new  = (rw_write && write_burst_mode_bit) ? 4'h1 : len_of(burst_count_setting);
  assign beat     = rw_go || (act_q && !stop);
  assign col      = rw_go ? addr[CW-1:0]
                          : col_of(start_q, beat_q, len_q, page_q, burst_order_bit);
  assign rd_beat  = beat && (rw_go ? !rw_write : !wr_q);
  assign wr_beat  = beat && (rw_go ? rw_write : wr_q);

  // Burst engine; a new read or write truncates the running burst
  always_ff @(posedge clock) begin
    if (reset) begin
      act_q   <= 1'b0;
      wr_q    <= 1'b0;
      len_q   <= 4'h1;
      page_q  <= 1'b0;
      start_q <= '0;
      beat_q  <= '0;
      bank_q  <= '0;
    end else if (rw_go) begin
      wr_q    <= rw_write;
      page_q  <= page_mode && !(rw_write && write_burst_mode_bit);
      len_q   <= len_new;
      act_q   <= len_new != 4'h1 || (page_mode && !(rw_write && write_burst_mode_bit));
      start_q <= addr[CW-1:0];
      beat_q  <= 9'h001;
      bank_q  <= bank;
    end else if (beat) begin
      beat_q <= beat_q + 1'b1;
      act_q  <= page_q || beat_q != CW'(len_q) - 1'b1;
    end else begin
      act_q <= 1'b0;
    end
  end

  // Read pipeline: stage 0 at edge n, driven after n+1 or n+2 by latency
  always_ff @(posedge clock) begin
    if (reset || load_ok) begin
      pv_q   <= '0;
      oe_n_q <= 1'b1;
      pd0_q  <= '0;
      pd1_q  <= '0;
      dq_q   <= '0;
    end else begin
      pv_q  <= {pv_q[0], rd_beat};
      pd0_q <= mem[{rw_go ? bank : bank_q, col}];
      pd1_q <= pd0_q;
      dq_q  <= lat3 ? pd1_q : pd0_q;
      oe_n_q <= !(lat3 ? pv_q[1] : pv_q[0]);
    end
  end

  // Write beats queue up so array updates can yield to reads
  sdm_fifo #(
    .W(FW),
    .D(`SDM_FIFO_D)
  ) u_wfifo (
    .clock    (clock),
    .reset    (reset),
    .in_valid (wr_beat),
    .in_ready (wr_fifo_ready),
    .in_data  ({rw_go ? bank : bank_q, col, dq_in}),
    .out_valid(drain_valid),
    .out_ready(!rd_beat),
    .out_data (drain_data)
  );

  // Single-port array: a read beat stalls the drain for that cycle
  always_ff @(posedge clock) begin
    if (drain_valid && !rd_beat) begin
      mem[drain_data[FW-1:`SDM_DQ_W]] <= drain_data[`SDM_DQ_W-1:0];
    end
  end

  assign dq_out     = dq_q;
  assign dq_oe_n    = oe_n_q;
  assign init_ready = state_q == SDM_ST_READY;
  assign seq_error  = err_q;
  assign mode_value = mode_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_read_lat2;
    rw_go && !rw_write && !lat3;
  endsequence
  sequence s_read_lat3;
    rw_go && !rw_write && lat3;
  endsequence
  sequence s_quiet2;
    !load_ok ##1 !load_ok;
  endsequence

  a_mode_load: assert property (load_ok |=> mode_q == $past(addr))
    else $error("mode value not captured on load");
  a_mode_hold: assert property (!load_ok |=> $stable(mode_q))
    else $error("mode value changed without a load");
  a_load_quiet: assert property (load_ok |=> dq_oe_n)
    else $error("outputs driven right after mode load");
  a_lat_two: assert property (s_read_lat2 ##0 s_quiet2 |=> !dq_oe_n)
    else $error("latency two read not driven at n+1");
  a_lat_three: assert property (s_read_lat3 ##1 (!load_ok && lat3) ##1 !load_ok
                                |=> !dq_oe_n)
    else $error("latency three read not driven at n+2");
  // A new read or write may truncate a burst, so its own edge is left out
  a_block_stay: assert property (act_q && !page_q && !rw_go |->
                                 ((col ^ start_q) & ~(CW'(len_q) - 1'b1)) == '0)
    else $error("burst left its aligned block");
  a_page_wrap: assert property (act_q && page_q && !stop && !rw_go && col == 9'h1FF
                                |=> col == 9'h000)
    else $error("page burst did not wrap to column zero");
  a_single_beat: assert property (rw_go && len_new == 4'h1 && !page_mode |=> !act_q)
    else $error("single location burst did not end");
  a_write_single: assert property (rw_go && rw_write && write_burst_mode_bit |=> !act_q)
    else $error("write burst mode ignored");
  a_ilv_order: assert property (act_q && !rw_go && !page_q && burst_order_bit && len_q == 4'h4 |->
                                col[1:0] == (start_q[1:0] ^ beat_q[1:0]))
    else $error("interleaved order wrong");
  a_seq_order: assert property (act_q && !rw_go && !page_q && !burst_order_bit && len_q == 4'h8 |->
                                col[2:0] == 3'(start_q[2:0] + beat_q[2:0]))
    else $error("sequential order wrong");
  a_ready_gate: assert property (init_ready |-> loaded_q && ref_q >= 2'h2)
    else $error("ready without refreshes and mode load");
endmodule

/* logic/sdm_cfg.svh */
// Constants for the synchronous DRAM init, mode and burst block
`ifndef SDM_CFG_SVH
`define SDM_CFG_SVH
`define SDM_CLK_NS 10
`define SDM_PWR_US 100
`define SDM_PWR_CYC ((`SDM_PWR_US * 1000) / `SDM_CLK_NS)
`define SDM_TRP_NS 20
`define SDM_TRP_CYC ((`SDM_TRP_NS + `SDM_CLK_NS - 1) / `SDM_CLK_NS)
`define SDM_REFRESH_CYCLE_WAIT_TIME_NS 66
`define SDM_REFRESH_CYCLE_WAIT_TIME_CYC ((`SDM_REFRESH_CYCLE_WAIT_TIME_NS + `SDM_CLK_NS - 1) / `SDM_CLK_NS)
`define SDM_MODE_LOAD_WAIT_TIME_CYC 2
`define SDM_REF_MIN 2
`define SDM_MODE_W 12
`define SDM_COL_W 9
`define SDM_DQ_W 16
`define SDM_FIFO_D 32
`define SDM_AP_BIT 10
`define SDM_F_LEN_LO 0
`define SDM_F_LEN_HI 2
`define SDM_F_ORDER 3
`define SDM_F_LAT_LO 4
`define SDM_F_LAT_HI 6
`define SDM_F_OPM_LO 7
`define SDM_F_OPM_HI 8
`define SDM_F_WBM 9
`define SDM_LEN_1 3'h0
`define SDM_LEN_2 3'h1
`define SDM_LEN_4 3'h2
`define SDM_LEN_8 3'h3
`define SDM_LEN_PAGE 3'h7
`define SDM_LAT_2 3'h2
`define SDM_LAT_3 3'h3
`define SDM_MODE_RST 12'h000
`endif

/* logic/sdm_pkg.sv */
// Types for the synchronous DRAM init, mode and burst block
package sdm_pkg;
  typedef enum logic [2:0] {
    SDM_CMD_LOAD  = 3'h0,
    SDM_CMD_REF   = 3'h1,
    SDM_CMD_PRE   = 3'h2,
    SDM_CMD_ACT   = 3'h3,
    SDM_CMD_WRITE = 3'h4,
    SDM_CMD_READ  = 3'h5,
    SDM_CMD_BST   = 3'h6,
    SDM_CMD_NOP   = 3'h7
  } sdm_cmd_t;
  typedef enum logic [1:0] {
    SDM_ST_POWER = 2'h0,
    SDM_ST_PRECH = 2'h1,
    SDM_ST_SETUP = 2'h3,
    SDM_ST_READY = 2'h2
  } sdm_state_t;
endpackage

/* sim/sdm_ctrl_model.sv */
// Memory controller model driving the DRAM command bus
`timescale 1ns/100ps
`include "sdm_cfg.svh"
module sdm_ctrl_model
  import sdm_pkg::*;
(
  input  wire logic                   clock,
  output logic                        cke,
  output logic                        cs_n,
  output logic                        ras_n,
  output logic                        cas_n,
  output logic                        we_n,
  output logic                        bank_select_low,
  output logic                        bank_select_high,
  output logic      [`SDM_MODE_W-1:0] addr,
  output logic      [`SDM_DQ_W-1:0]   dq_in
);
  // Bank bits for the next command; loads are legal only while this is zero
  logic [1:0] bank_sel = 2'h0;
  initial begin
    cke = 1'b0;
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = SDM_CMD_NOP;
    {bank_select_high, bank_select_low} = 2'h0;
    addr = 12'h000;
    dq_in = 16'h0000;
  end
  // Drive only; caller stands just after a rising edge
  task automatic put(input sdm_cmd_t c, input logic [11:0] a, input logic [15:0] d);
    cs_n <= 1'b0;
    {ras_n, cas_n, we_n} <= c;
    {bank_select_high, bank_select_low} <= bank_sel;
    addr <= a;
    dq_in <= d;
  endtask
  // Idle lines toggle so a stale value never looks valid
  task automatic idle();
    cs_n <= 1'b1;
    {ras_n, cas_n, we_n} <= SDM_CMD_NOP;
    addr <= ~addr;
    dq_in <= ~dq_in;
  endtask
  task automatic cmd(input sdm_cmd_t c, input logic [11:0] a, input logic [15:0] d);
    put(c, a, d);
    @(posedge clock);
  endtask
  task automatic nop(input int n);
    repeat (n) begin
      idle();
      @(posedge clock);
    end
  endtask
  task automatic init_seq(input int pwr, input logic [11:0] mode);
    nop(pwr / 2);
    cke <= 1'b1;
    nop(pwr / 2 + 2);
    cmd(SDM_CMD_PRE, 12'h400, dq_in);
    nop(2);
    cmd(SDM_CMD_REF, addr, dq_in);
    nop(6);
    // Load placed between refreshes, which the device must accept
    cmd(SDM_CMD_LOAD, mode, dq_in);
    nop(1);
    repeat (2) begin
      cmd(SDM_CMD_REF, addr, dq_in);
      nop(6);
    end
  endtask
endmodule

/* sim/sdm_init_mode_burst_test.sv */
// Testbench for the DRAM init, mode register and burst ordering
`timescale 1ns/100ps
`include "sdm_cfg.svh"
module sdm_init_mode_burst_test
  import sdm_pkg::*;
;
  localparam int PWR = 20;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic        cke, cs_n, ras_n, cas_n, we_n, bsl, bsh;
  logic [11:0] addr;
  logic [15:0] dq_in;
  logic [15:0] dq_out;
  logic        dq_oe_n, init_ready, seq_error, wr_fifo_ready;
  logic [11:0] mode_value;
  logic [15:0] mem [0:511];
  int          fails = 0;
  int          cmp_count = 0;

  always #5 clock = ~clock;

  sdm_ctrl_model u_ctl (
    .clock(clock), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .bank_select_low(bsl), .bank_select_high(bsh), .addr(addr), .dq_in(dq_in)
  );
  sdm_device #(.PWR_CYC(PWR)) u_dut (
    .clock(clock), .reset(reset), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .bank_select_low(bsl), .bank_select_high(bsh), .addr(addr),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .init_ready(init_ready),
    .seq_error(seq_error), .mode_value(mode_value), .wr_fifo_ready(wr_fifo_ready)
  );

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  function automatic logic [11:0] mk(input logic [2:0] len, input logic ilv,
                                     input logic [2:0] lat, input logic wbm);
    return {2'h0, wbm, 2'h0, lat, ilv, len};
  endfunction
  // Page bursts use span 512, so the mask covers the whole row
  function automatic logic [8:0] col_at(input logic [8:0] s, input int span,
                                        input logic ilv, input int i);
    logic [8:0] m;
    m = 9'(span - 1);
    return (s & ~m) | ((ilv ? (s ^ 9'(i)) : 9'(s + 9'(i))) & m);
  endfunction
  task automatic set_mode(input logic [11:0] m);
    u_ctl.cmd(SDM_CMD_LOAD, m, u_ctl.dq_in);
    u_ctl.nop(1);
    @(negedge clock);
    check("mode_value", 16'(mode_value), 16'(m));
    @(posedge clock);
  endtask
  task automatic wr(input logic [8:0] c, input logic [15:0] d);
    u_ctl.cmd(SDM_CMD_WRITE, {3'h0, c}, d);
    mem[c] = d;
  endtask
  // Span above beats means a page burst, stopped by burst terminate
  task automatic rd(input logic [8:0] s, input int beats, input int span,
                    input logic ilv, input int lat);
    u_ctl.cmd(SDM_CMD_READ, {3'h0, s}, u_ctl.dq_in);
    for (int k = 0; k <= lat - 1 + beats; k++) begin
      if (span > beats && k == beats - 1) begin
        u_ctl.put(SDM_CMD_BST, u_ctl.addr, u_ctl.dq_in);
      end else begin
        u_ctl.idle();
      end
      @(negedge clock);
      if (k >= lat - 1 && k < lat - 1 + beats) begin
        check("dq_oe_n beat", 16'(dq_oe_n), 16'h0000);
        check("dq_out", dq_out, mem[col_at(s, span, ilv, k - lat + 1)]);
      end else begin
        check("dq_oe_n idle", 16'(dq_oe_n), 16'h0001);
      end
      @(posedge clock);
    end
  endtask

  initial begin
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    u_ctl.nop(3);
    u_ctl.cke <= 1'b1;
    u_ctl.cmd(SDM_CMD_READ, 12'h003, u_ctl.dq_in);
    u_ctl.nop(2);
    @(negedge clock);
    check("seq_error early", 16'(seq_error), 16'h0001);
    check("dq_oe_n early", 16'(dq_oe_n), 16'h0001);
    check("init_ready early", 16'(init_ready), 16'h0000);
    @(posedge clock);
    reset <= 1'b1;
    u_ctl.cke <= 1'b0;
    repeat (6) @(posedge clock);
    @(negedge clock);
    check("seq_error rst", 16'(seq_error), 16'h0000);
    check("mode_value rst", 16'(mode_value), 16'h0000);
    check("dq_oe_n rst", 16'(dq_oe_n), 16'h0001);
    check("wr_fifo_ready rst", 16'(wr_fifo_ready), 16'h0001);
    @(posedge clock);
    reset <= 1'b0;
    u_ctl.init_seq(PWR, mk(`SDM_LEN_1, 1'b0, `SDM_LAT_2, 1'b0));
    u_ctl.nop(2);
    @(negedge clock);
    check("init_ready", 16'(init_ready), 16'h0001);
    check("seq_error init", 16'(seq_error), 16'h0000);
    check("mode_value init", 16'(mode_value), 16'h0020);
    @(posedge clock);
    for (int c = 0; c < 36; c++) begin
      wr(9'(c < 32 ? c : c + 476), 16'hC000 + 16'(c));
    end
    u_ctl.nop(8);
    set_mode(mk(`SDM_LEN_4, 1'b0, `SDM_LAT_2, 1'b0));
    rd(9'h003, 4, 4, 1'b0, 2);
    set_mode(mk(`SDM_LEN_4, 1'b1, `SDM_LAT_3, 1'b0));
    rd(9'h001, 4, 4, 1'b1, 3);
    set_mode(mk(`SDM_LEN_8, 1'b1, `SDM_LAT_2, 1'b0));
    rd(9'h00D, 8, 8, 1'b1, 2);
    rd(9'h01E, 8, 8, 1'b1, 2);
    set_mode(mk(`SDM_LEN_1, 1'b1, `SDM_LAT_3, 1'b0));
    rd(9'h007, 1, 1, 1'b1, 3);
    set_mode(mk(`SDM_LEN_PAGE, 1'b0, `SDM_LAT_2, 1'b0));
    rd(9'h1FE, 4, 512, 1'b0, 2);
    // Single writes under a long read length leave neighbours untouched
    set_mode(mk(`SDM_LEN_8, 1'b0, `SDM_LAT_2, 1'b1));
    wr(9'h010, 16'h5A5A);
    u_ctl.nop(8);
    rd(9'h010, 8, 8, 1'b0, 2);
    set_mode(mk(`SDM_LEN_2, 1'b0, `SDM_LAT_2, 1'b0));
    wr(9'h005, 16'h1234);
    u_ctl.cmd(SDM_CMD_NOP, u_ctl.addr, 16'hABCD);
    mem[4] = 16'hABCD;
    u_ctl.nop(8);
    rd(9'h004, 2, 2, 1'b0, 2);
    @(negedge clock);
    check("seq_error end", 16'(seq_error), 16'h0000);
    check("wr_fifo_ready end", 16'(wr_fifo_ready), 16'h0001);
    @(posedge clock);
    // Another bank keeps its own columns
    u_ctl.bank_sel = 2'h2;
    u_ctl.cmd(SDM_CMD_WRITE, 12'h004, 16'h0BB0);
    u_ctl.cmd(SDM_CMD_NOP, u_ctl.addr, 16'h0BB1);
    u_ctl.nop(8);
    mem[4] = 16'h0BB0;
    mem[5] = 16'h0BB1;
    rd(9'h004, 2, 2, 1'b0, 2);
    u_ctl.bank_sel = 2'h0;
    mem[4] = 16'hABCD;
    mem[5] = 16'h1234;
    rd(9'h004, 2, 2, 1'b0, 2);
    // A load with a bank bit set is refused and flagged
    u_ctl.bank_sel = 2'h1;
    u_ctl.cmd(SDM_CMD_LOAD, 12'h033, u_ctl.dq_in);
    u_ctl.nop(2);
    @(negedge clock);
    check("mode_value bank", 16'(mode_value), 16'h0021);
    check("seq_error bank", 16'(seq_error), 16'h0001);
    finish_test();
  end

  initial begin
    #100000;
    fails++;
    finish_test();
  end
endmodule
